// >>> carf_pkg.sv
// carf_pkg: shared constants and carrier types for the architectural register file
// assumes a single core clock domain; no software-visible registers
package carf_pkg;

    // widths fixed at the 64-bit variant; the 32-bit variant uses the low half
    localparam int unsigned XLEN           = 64;       // general register width
    localparam int unsigned NREGS          = 32;       // general registers
    localparam int unsigned FNREGS         = 32;       // float bank registers
    localparam int unsigned AW             = 5;        // register index width
    localparam logic [4:0]  ZERO_IDX       = 5'h00;    // hard-wired zero register
    localparam logic [4:0]  LINK_IDX       = 5'h1f;    // fixed link register
    localparam logic [63:0] RESET_VALUE    = 64'h0000_0000_0000_0000;
    localparam logic [31:0] SP_RESET_VALUE = 32'h0000_0000;

    // processor variant strapped by the integrating core
    typedef enum logic [1:0] {
        CARF_V32    = 2'h0,        // 32-bit core, paired float registers
        CARF_V64    = 2'h1,        // 64-bit double-capable core
        CARF_VSP    = 2'h2         // 64-bit core, single precision float only
    } carf_variant_t;

    // how the destination of a general write was chosen
    typedef enum logic [1:0] {
        CARF_WR_RD,                // plain result, named destination
        CARF_WR_LINK,              // immediate call / branch-and-link
        CARF_WR_LINK_REG           // register-indirect call, named destination
    } carf_wr_kind_t;

    // result pair operations
    typedef enum logic [2:0] {
        CARF_MD_NONE,
        CARF_MD_MUL,               // product into high:low
        CARF_MD_DIV,               // quotient low, remainder high
        CARF_MD_MACC,              // accumulate into high:low
        CARF_MD_MSUB,              // subtract from high:low
        CARF_MD_SET_HI,            // move to high
        CARF_MD_SET_LO             // move to low
    } carf_md_op_t;

    // general register write request
    typedef struct packed {
        logic          en;
        carf_wr_kind_t kind;
        logic [4:0]    idx;
        logic [63:0]   data;
    } carf_gwr_t;

    // result pair update from the multiply/divide unit
    typedef struct packed {
        logic          en;
        carf_md_op_t   op;
        logic [63:0]   a;          // product high / remainder / move value
        logic [63:0]   b;          // product low / quotient
    } carf_md_t;

    // float register access
    typedef struct packed {
        logic          en;
        logic          arith;      // arithmetic operand, not a move/load/store
        logic          dbl;        // double precision operand
        logic [4:0]    idx;
    } carf_facc_t;

    // float write carries data too
    typedef struct packed {
        carf_facc_t    acc;
        logic [63:0]   data;
    } carf_fwr_t;

endpackage : carf_pkg

// >>> carf_fpbank.sv
// carf_fpbank: floating-point register bank with layout selected by the mode bit
// assumes the caller registers the read results; reads here are combinational
`timescale 1ns/1ps
module carf_fpbank
    import carf_pkg::*;
(
    input  wire logic          clk_in,
    input  wire logic          arst_n_in,
    input  wire carf_variant_t variant_in,     // processor variant
    input  wire logic          layout_in,      // float_bank_layout_bit
    input  wire carf_facc_t    rd_in,          // read request
    input  wire carf_fwr_t     wr_in,          // write request
    output logic [63:0]        rdata_out,      // read value
    output logic               illegal_out     // request not allowed by layout
);

    logic [31:0] bank_q [FNREGS];              // one 32-bit half per register
    logic [31:0] bhi_q  [FNREGS];              // upper halves, used when wide

    // legality of an access under the current layout
    function automatic logic legal(input carf_facc_t a, input carf_variant_t v, input logic fr);
        legal = 1'b1;
        if (a.en && a.arith) begin
            if (v == CARF_V32 && a.idx[0]) begin
                legal = 1'b0;
            end else if (v != CARF_V32 && !fr && a.idx[0]) begin
                legal = (v == CARF_V64) ? !a.dbl : 1'b0;
            end
            if (v == CARF_VSP && a.dbl) begin
                legal = 1'b0;
            end
        end
    endfunction : legal

    // true when a double lives split across an even/odd pair
    function automatic logic paired(input carf_variant_t v, input logic fr);
        paired = (v == CARF_V32) || (v == CARF_V64 && !fr);
    endfunction : paired

    ////////////////////////////////////////////////////////////////////////////
    // write port
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < FNREGS; i++) begin
                bank_q[i] <= SP_RESET_VALUE;
                bhi_q[i]  <= SP_RESET_VALUE;
            end
        end else if (wr_in.acc.en && legal(wr_in.acc, variant_in, layout_in)) begin
            if (wr_in.acc.dbl && paired(variant_in, layout_in)) begin
                // even holds high word, next odd the low-order bits
                bank_q[{wr_in.acc.idx[4:1], 1'b0}] <= wr_in.data[63:32];
                bank_q[{wr_in.acc.idx[4:1], 1'b1}] <= wr_in.data[31:0];
            end else begin
                bank_q[wr_in.acc.idx] <= wr_in.data[31:0];
                bhi_q[wr_in.acc.idx]  <= wr_in.data[63:32];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port
    always_comb begin
        rdata_out   = 64'h0000_0000_0000_0000;
        illegal_out = rd_in.en && !legal(rd_in, variant_in, layout_in);
        if (rd_in.dbl && paired(variant_in, layout_in)) begin
            rdata_out = {bank_q[{rd_in.idx[4:1], 1'b0}], bank_q[{rd_in.idx[4:1], 1'b1}]};
        end else if (variant_in == CARF_VSP || !rd_in.dbl && !layout_in) begin
            rdata_out = {32'h0000_0000, bank_q[rd_in.idx]};
        end else begin
            rdata_out = {bhi_q[rd_in.idx], bank_q[rd_in.idx]};
        end
    end

endmodule : carf_fpbank

// >>> carf_regfile.sv
// carf_regfile: architectural register file, result pair and float bank
// assumes decode presents fixed source fields each cycle and writeback one result
`timescale 1ns/1ps
//
// Contract
// - 32 general registers, 32 or 64 wide
// - register zero reads zero, writes dropped
// - call and branch-and-link write register 31
// - indirect call writes its named register
// - other registers identical, no pc or flags
// - high/low pair holds product or quotient/remainder
// - pair acts as multiply-accumulate accumulator
// - three-operand multiply leaves pair unchanged
// - separate 32-entry float bank, chosen by instruction
// - 32-bit variant: only even float regs arithmetic
// - double pairs even register with next odd
// - odd float regs only for moves, loads, stores
// - mode clear: sixteen doubles or thirty-two singles
// - mode set: thirty-two 64-bit registers
// - single-only: sixteen or thirty-two 32-bit registers
// - divide: quotient low, remainder high
// - pair read before completion stalls the pipe
// - two source reads every clock, fixed fields
module carf_regfile
    import carf_pkg::*;
(
    input  wire logic          clk_in,
    input  wire logic          arst_n_in,
    input  wire carf_variant_t variant_in,     // processor variant strap
    input  wire logic          float_coprocessor_in,   // float bank present
    input  wire logic          float_bank_layout_bit_in, // status mode bit
    input  wire logic [31:0]   instr_in,       // instruction in decode
    input  wire carf_gwr_t     gwr_in,         // general result write
    input  wire carf_md_t      md_in,          // result pair update
    input  wire logic          md_busy_in,     // multiply/divide in flight
    input  wire logic          md_rd_hi_in,    // decode wants high result
    input  wire logic          md_rd_lo_in,    // decode wants low result
    input  wire carf_facc_t    frd_in,         // float read
    input  wire carf_fwr_t     fwr_in,         // float write
    output logic [63:0]        src_a_out,      // first source operand
    output logic [63:0]        src_b_out,      // second source operand
    output logic [63:0]        mul_result_high_out,
    output logic [63:0]        mul_result_low_out,
    output logic               stall_out,      // pair read must wait
    output logic [63:0]        frdata_out,     // float read value
    output logic               fillegal_out    // float access refused
);

    ////////////////////////////////////////////////////////////////////////////
    // storage
    logic [63:0] gpr_q [NREGS];                // general registers
    logic [63:0] hi_q;                         // mul_result_high
    logic [63:0] lo_q;                         // mul_result_low
    logic [4:0]  wr_idx;                       // resolved destination
    logic        wr_en;                        // effective general write
    logic [63:0] wr_data;                      // write value sized to variant
    logic [63:0] src_a_d;
    logic [63:0] src_b_d;
    logic [63:0] fr_data;
    logic        fr_ill;
    logic        f_en_rd;
    logic [127:0] acc_sum;                     // accumulator arithmetic

    // trim a value to the width of the variant; upper half zero on 32-bit
    function automatic logic [63:0] vtrim(input logic [63:0] v, input carf_variant_t k);
        vtrim = (k == CARF_V32) ? {32'h0000_0000, v[31:0]} : v;
    endfunction : vtrim

    // pair as one accumulator; on the 32-bit variant the carry must cross at bit 32, not 64
    function automatic logic [127:0] pack_pair(input logic [63:0] h, input logic [63:0] l,
                                               input carf_variant_t k);
        pack_pair = (k == CARF_V32) ? {64'h0000_0000_0000_0000, h[31:0], l[31:0]} : {h, l};
    endfunction : pack_pair

    // read a general register with zero and write bypass
    function automatic logic [63:0] gread(input logic [4:0] i, input logic we,
                                          input logic [4:0] wi, input logic [63:0] wd,
                                          input logic [63:0] st);
        if (i == ZERO_IDX) begin
            gread = RESET_VALUE;
        end else if (we && wi == i) begin
            gread = wd;
        end else begin
            gread = st;
        end
    endfunction : gread

    ////////////////////////////////////////////////////////////////////////////
    // destination resolution
    always_comb begin
        // link writes always target register 31; indirect calls keep their field
        wr_idx  = (gwr_in.kind == CARF_WR_LINK) ? LINK_IDX : gwr_in.idx;
        wr_en   = gwr_in.en && (wr_idx != ZERO_IDX);
        wr_data = vtrim(gwr_in.data, variant_in);
    end

    // general write, one per clock; all non-zero entries alike
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int i = 0; i < NREGS; i++) begin
                gpr_q[i] <= RESET_VALUE;
            end
        end else if (wr_en) begin
            gpr_q[wr_idx] <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source reads from fixed fields; no decode on opcode
    always_comb begin
        src_a_d = gread(instr_in[25:21], wr_en, wr_idx, wr_data, gpr_q[instr_in[25:21]]);
        src_b_d = gread(instr_in[20:16], wr_en, wr_idx, wr_data, gpr_q[instr_in[20:16]]);
    end

    // operands registered so outputs come straight from flops
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            src_a_out <= RESET_VALUE;
            src_b_out <= RESET_VALUE;
        end else begin
            src_a_out <= src_a_d;
            src_b_out <= src_b_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result pair; a three-operand multiply goes through gwr_in only
    always_comb begin
        acc_sum = pack_pair(hi_q, lo_q, variant_in);
        if (md_in.op == CARF_MD_MACC) begin
            acc_sum = pack_pair(hi_q, lo_q, variant_in) + pack_pair(md_in.a, md_in.b, variant_in);
        end else if (md_in.op == CARF_MD_MSUB) begin
            acc_sum = pack_pair(hi_q, lo_q, variant_in) - pack_pair(md_in.a, md_in.b, variant_in);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hi_q <= RESET_VALUE;
            lo_q <= RESET_VALUE;
        end else if (md_in.en) begin
            unique case (md_in.op)
                CARF_MD_NONE: begin
                    hi_q <= hi_q;
                end
                CARF_MD_MUL: begin
                    hi_q <= vtrim(md_in.a, variant_in);
                    lo_q <= vtrim(md_in.b, variant_in);
                end
                CARF_MD_DIV: begin
                    lo_q <= vtrim(md_in.b, variant_in);
                    hi_q <= vtrim(md_in.a, variant_in);
                end
                CARF_MD_MACC, CARF_MD_MSUB: begin
                    // 32-bit variant: the sum sits in the low 64 bits
                    if (variant_in == CARF_V32) begin
                        hi_q <= {32'h0000_0000, acc_sum[63:32]};
                        lo_q <= {32'h0000_0000, acc_sum[31:0]};
                    end else begin
                        hi_q <= acc_sum[127:64];
                        lo_q <= acc_sum[63:0];
                    end
                end
                CARF_MD_SET_HI: begin
                    hi_q <= vtrim(md_in.a, variant_in);
                end
                CARF_MD_SET_LO: begin
                    lo_q <= vtrim(md_in.a, variant_in);
                end
                default: begin
                    hi_q <= hi_q;
                end
            endcase
        end
    end

    // published pair and interlock
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mul_result_high_out <= RESET_VALUE;
            mul_result_low_out  <= RESET_VALUE;
            stall_out           <= 1'b0;
        end else begin
            mul_result_high_out <= hi_q;
            mul_result_low_out  <= lo_q;
            // held until the unit drops busy, then the read proceeds
            stall_out           <= md_busy_in && (md_rd_hi_in || md_rd_lo_in);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // float bank, only when the coprocessor is present
    assign f_en_rd = frd_in.en && float_coprocessor_in;

    carf_fpbank u_fpbank (
        .clk_in      (clk_in),
        .arst_n_in   (arst_n_in),
        .variant_in  (variant_in),
        .layout_in   (float_bank_layout_bit_in),
        .rd_in       ('{en: f_en_rd, arith: frd_in.arith, dbl: frd_in.dbl, idx: frd_in.idx}),
        .wr_in       ('{acc: '{en: fwr_in.acc.en && float_coprocessor_in, arith: fwr_in.acc.arith,
                              dbl: fwr_in.acc.dbl, idx: fwr_in.acc.idx}, data: fwr_in.data}),
        .rdata_out   (fr_data),
        .illegal_out (fr_ill)
    );

    // float read registered; separate bank from general file
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            frdata_out   <= RESET_VALUE;
            fillegal_out <= 1'b0;
        end else begin
            frdata_out   <= f_en_rd ? fr_data : RESET_VALUE;
            fillegal_out <= fr_ill;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    zero_reads_zero_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        instr_in[25:21] == ZERO_IDX |=> src_a_out == RESET_VALUE)
        else $error("register zero read nonzero");

    link_dest_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        gwr_in.en && gwr_in.kind == CARF_WR_LINK |=> gpr_q[LINK_IDX] == $past(wr_data))
        else $error("link write missed register 31");

    indirect_dest_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        gwr_in.en && gwr_in.kind == CARF_WR_LINK_REG && gwr_in.idx != ZERO_IDX
        |=> gpr_q[$past(gwr_in.idx)] == $past(wr_data))
        else $error("indirect call link not written");

    bypass_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        wr_en && instr_in[20:16] == wr_idx |=> src_b_out == $past(wr_data))
        else $error("bypass value wrong");

    div_split_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        md_in.en && md_in.op == CARF_MD_DIV |=> lo_q == vtrim($past(md_in.b), $past(variant_in))
        && hi_q == vtrim($past(md_in.a), $past(variant_in)) ##1 mul_result_high_out == $past(hi_q))
        else $error("divide results misplaced");

    pair_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !md_in.en |=> $stable(hi_q) && $stable(lo_q))
        else $error("pair changed without update");

    stall_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        md_busy_in && md_rd_lo_in |=> stall_out)
        else $error("pair read not stalled");

    odd_arith_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        f_en_rd && frd_in.arith && variant_in == CARF_V32 && frd_in.idx[0] |=> fillegal_out)
        else $error("odd arithmetic operand accepted");

endmodule : carf_regfile

// >>> carf_pipe_model.sv
// carf_pipe_model: multiply/divide side of the execute pipe facing the register file
// assumes the bench calls issue 1ns after a rising edge of clk_in
`timescale 1ns/1ps
module carf_pipe_model
    import carf_pkg::*;
(
    input  wire logic clk_in,      // core clock
    output carf_md_t  md_out,      // result pair update
    output logic      busy_out     // operation in flight
);
    ////////////////////////////////////////////////////////////////////////////
    // idle at time zero: nothing in flight
    initial begin
        md_out   = '0;
        busy_out = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one operation: busy for lat cycles, then a single update cycle
    // lat 0 answers at once; a larger lat models a slow divide
    task automatic issue(input carf_md_op_t op, input logic [63:0] a, input logic [63:0] b, input int lat);
        if (lat > 0) begin
            busy_out = 1'b1;
            repeat (lat) begin
                @(posedge clk_in);
                #1;
            end
            busy_out = 1'b0;
        end
        md_out   = '{en: 1'b1, op: op, a: a, b: b};
        @(posedge clk_in);
        #1;
        // released: operands inverted so an ignored enable shows up
        md_out   = '{en: 1'b0, op: CARF_MD_NONE, a: ~a, b: ~b};
    endtask : issue
endmodule : carf_pipe_model

// >>> carf_regfile_tb_top.sv
// carf_regfile_tb_top: self-checking bench for the architectural register file
// assumes inputs move 1ns after the rising edge, when registered outputs have settled
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; $display("Error %s expected %h seen %h", nm, exp, got); end end
module carf_regfile_tb_top
    import carf_pkg::*;
;
    logic          clk;              // core clock, 25 ns
    logic          arst_n;           // async reset, active low
    carf_variant_t variant;          // variant strap
    logic          fcop;             // float bank present
    logic          layout;           // float_bank_layout_bit
    logic [31:0]   instr;            // decode word
    carf_gwr_t     gwr;              // general write
    logic          rd_hi;            // decode wants high result
    logic          rd_lo;            // decode wants low result
    carf_facc_t    frd;              // float read
    carf_fwr_t     fwr;              // float write
    carf_md_t      md;               // from the pipe model
    logic          md_busy;          // from the pipe model
    logic [63:0]   src_a;            // first operand
    logic [63:0]   src_b;            // second operand
    logic [63:0]   hi;               // high result copy
    logic [63:0]   lo;               // low result copy
    logic [63:0]   fdata;            // float read value
    logic          stall;            // pair read held off
    logic          fill;             // float access refused
    int            n_fail;           // mismatches
    int            samples_checked;  // comparisons made

    ////////////////////////////////////////////////////////////////////////////
    // clock and design
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    carf_regfile uut (.clk_in(clk), .arst_n_in(arst_n), .variant_in(variant), .float_coprocessor_in(fcop),
        .float_bank_layout_bit_in(layout), .instr_in(instr), .gwr_in(gwr), .md_in(md), .md_busy_in(md_busy),
        .md_rd_hi_in(rd_hi), .md_rd_lo_in(rd_lo), .frd_in(frd), .fwr_in(fwr), .src_a_out(src_a),
        .src_b_out(src_b), .mul_result_high_out(hi), .mul_result_low_out(lo), .stall_out(stall),
        .frdata_out(fdata), .fillegal_out(fill));

    carf_pipe_model pipe (.clk_in(clk), .md_out(md), .busy_out(md_busy));

    ////////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    // distinct value per register index, full width
    function automatic logic [63:0] pat(input int i);
        return 64'h0F1E_2D3C_4B5A_6978 ^ {8{8'(i)}};
    endfunction : pat

    // hold reset two edges; src_a, high result, stall and float data must read zero meanwhile
    task automatic do_reset();
        arst_n = 1'b0;
        repeat (2) tick();
        `CHK("src_a_out", 64'h0, src_a)
        `CHK("mul_result_high_out", 64'h0, hi)
        `CHK("stall_out", 1'b0, stall)
        `CHK("frdata_out", 64'h0, fdata)
        arst_n = 1'b1;
    endtask : do_reset

    // one decode cycle with an optional write; the request stands until the next call
    task automatic step(input carf_gwr_t w, input logic [4:0] a, input logic [4:0] b);
        gwr   = w;
        instr = {6'h00, a, b, 16'h0000};
        tick();
    endtask : step

    // pair update then look two cycles on
    task automatic md_chk(input carf_md_op_t op, input logic [63:0] a, b, ehi, elo);
        pipe.issue(op, a, b, 0);
        tick();
        `CHK("mul_result_high_out", ehi, hi)
        `CHK("mul_result_low_out", elo, lo)
    endtask : md_chk

    task automatic fw(input logic ar, dbl, input logic [4:0] ix, input logic [63:0] d);
        fwr = '{'{1'b1, ar, dbl, ix}, d};
        tick();
    endtask : fw

    // data is only judged when the access is legal
    task automatic fr(input logic ar, dbl, input logic [4:0] ix, input logic [63:0] ed, input logic ei);
        fwr.acc.en = 1'b0;
        frd = '{1'b1, ar, dbl, ix};
        tick();
        `CHK("fillegal_out", ei, fill)
        if (!ei) `CHK("frdata_out", ed, fdata)
    endtask : fr

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_gpr();
        step('{1'b1, CARF_WR_RD, 5'h00, '1}, 5'h00, 5'h00);
        `CHK("zero bypass", 64'h0, src_a)
        for (int i = 1; i < 32; i++) step('{1'b1, CARF_WR_RD, 5'(i), pat(i)}, 5'h00, 5'h00);
        for (int i = 0; i < 32; i++) begin
            step('0, 5'(i), 5'(31 - i));
            `CHK("src_a_out", (i == 0) ? 64'h0 : pat(i), src_a)
            `CHK("src_b_out", (i == 31) ? 64'h0 : pat(31 - i), src_b)
        end
    endtask : t_gpr

    task automatic t_link();
        step('{1'b1, CARF_WR_LINK, 5'h05, 64'h1111_2222_3333_4444}, 5'h1f, 5'h05);
        `CHK("link bypass", 64'h1111_2222_3333_4444, src_a)
        `CHK("named reg kept", pat(5), src_b)
        step('{1'b1, CARF_WR_LINK_REG, 5'h07, 64'h5555_6666_7777_8888}, 5'h07, 5'h1f);
        `CHK("indirect bypass", 64'h5555_6666_7777_8888, src_a)
        `CHK("link reg kept", 64'h1111_2222_3333_4444, src_b)
        step('0, 5'h07, 5'h1f);
        `CHK("indirect stored", 64'h5555_6666_7777_8888, src_a)
        `CHK("link stored", 64'h1111_2222_3333_4444, src_b)
    endtask : t_link

    // carries across the 64-bit halves prove the pair is one 128-bit accumulator
    task automatic t_pair();
        md_chk(CARF_MD_MUL, 64'h0, '1, 64'h0, '1);
        md_chk(CARF_MD_MACC, 64'h0, 64'h1, 64'h1, 64'h0);
        md_chk(CARF_MD_MSUB, 64'h0, 64'h1, 64'h0, '1);
        md_chk(CARF_MD_DIV, 64'h7, 64'h9, 64'h7, 64'h9);
        pipe.issue(CARF_MD_SET_HI, 64'hAA, '0, 0);
        tick();
        pipe.issue(CARF_MD_SET_LO, 64'hBB, '0, 0);
        tick();
        `CHK("high after moves", 64'hAA, hi)
        `CHK("low after moves", 64'hBB, lo)
        step('{1'b1, CARF_WR_RD, 5'h09, 64'h63}, 5'h09, 5'h09);
        `CHK("mul into general", 64'h63, src_a)
        `CHK("bypass on b", 64'h63, src_b)
        `CHK("high untouched", 64'hAA, hi)
        `CHK("low untouched", 64'hBB, lo)
        gwr = '0;
        do_reset();
    endtask : t_pair

    // a pair read while busy is held off; released once the result lands
    task automatic t_stall();
        rd_hi = 1'b1;
        fork
            pipe.issue(CARF_MD_MUL, 64'h0, 64'h2, 3);
            begin
                tick();
                `CHK("stall_out", 1'b1, stall)
            end
        join
        tick();
        `CHK("stall_out", 1'b0, stall)
        `CHK("low after stall", 64'h2, lo)
        rd_hi = 1'b0;
        rd_lo = 1'b1;
        fork
            pipe.issue(CARF_MD_DIV, 64'h1, 64'h3, 2);
            begin
                tick();
                `CHK("stall_out", 1'b1, stall)
            end
        join
        rd_lo = 1'b0;
    endtask : t_stall

    task automatic t_float();
        fw(1, 1, 5'h03, 64'hC0DE_0001_2345_6789);
        fr(1, 1, 5'h03, 64'hC0DE_0001_2345_6789, 0);
        step('0, 5'h03, 5'h00);
        `CHK("general reg 3", 64'h0, src_a)
        layout = 1'b0;
        fr(1, 1, 5'h03, '0, 1);
        fw(1, 1, 5'h02, 64'h0123_4567_89AB_CDEF);
        fr(1, 1, 5'h02, 64'h0123_4567_89AB_CDEF, 0);
        fr(1, 0, 5'h03, 64'h0000_0000_89AB_CDEF, 0);
        variant = CARF_V32;
        fw(0, 0, 5'h04, 64'h0000_0000_1111_2222);
        fw(0, 0, 5'h05, 64'h0000_0000_3333_4444);
        fr(1, 1, 5'h04, 64'h1111_2222_3333_4444, 0);
        fr(1, 0, 5'h05, '0, 1);
        fr(0, 0, 5'h05, 64'h0000_0000_3333_4444, 0);
        variant = CARF_VSP;
        fr(1, 1, 5'h02, '0, 1);
        fr(1, 0, 5'h03, '0, 1);
        layout = 1'b1;
        fw(1, 0, 5'h03, 64'h0000_0000_0BAD_F00D);
        fr(1, 0, 5'h03, 64'h0000_0000_0BAD_F00D, 0);
        // without the coprocessor the bank answers nothing
        fcop = 1'b0;
        frd  = '{1'b1, 1'b0, 1'b0, 5'h03};
        tick();
        frd.en = 1'b0;
        `CHK("frdata without bank", 64'h0, fdata)
        fcop = 1'b1;
    endtask : t_float

    // the 32-bit variant keeps only the low word
    task automatic t_trim();
        variant = CARF_V32;
        step('{1'b1, CARF_WR_RD, 5'h01, '1}, 5'h00, 5'h00);
        step('0, 5'h01, 5'h00);
        `CHK("trimmed reg 1", 64'h0000_0000_FFFF_FFFF, src_a)
    endtask : t_trim

    ////////////////////////////////////////////////////////////////////////////
    // verdict, main sequence and watchdog
    task automatic conclude();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    initial begin
        n_fail = 0;
        samples_checked = 0;
        variant = CARF_V64;
        fcop = 1'b1;
        layout = 1'b1;
        instr = '0;
        gwr = '0;
        rd_hi = 1'b0;
        rd_lo = 1'b0;
        frd = '0;
        fwr = '0;
        do_reset();
        t_gpr();
        t_link();
        t_pair();
        t_stall();
        t_float();
        t_trim();
        conclude();
    end

    // the run needs about a hundred and ten cycles; this cuts a hang short
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        conclude();
    end
endmodule : carf_regfile_tb_top
